// ===== common/abu_defines.svh
// Purpose: Constants for the address breakpoint unit.
// Assumes: Byte registers each sit in the low bits of one 32-bit AXI4-Lite word.
// Notes: The printed offsets are not all multiples of four, so each one is an index.
//        The byte address of a register is four times its index.
// Behaviour
// - Request break when address equals breakpoint
// - Integration unit forces software interrupt opcode
// - Break vector FFFC, FEFC in monitor mode
// - Only program counter fetches are compared
// - Writing one to active flag breaks
// - Return from interrupt ends break state
// - Match on last cycle breaks immediately
// - Timer counter halted during break
// - Watchdog disabled in break with high voltage
// - Flag clear during break needs enable; the code clears it on any control write with b6 zero, enable or not
// - Address high at FE0C, low FE0D
// - Control at FE0E: enable b7, active b6
// - Address breaks only while enable set
// - Match sets active flag; software clears
`ifndef ABU_DEFINES_SVH
`define ABU_DEFINES_SVH
`define ABU_IDX_ADDR_HIGH   16'hFE0C
`define ABU_IDX_ADDR_LOW    16'hFE0D
`define ABU_IDX_STAT_CTRL   16'hFE0E
`define ABU_IDX_IRQ_STATUS  16'hFE10
`define ABU_IDX_IRQ_MASK    16'hFE11
`define ABU_IDX_SIM_CTRL    16'hFE12
`define ABU_BIT_ENABLE      7
`define ABU_BIT_ACTIVE      6
`define ABU_VEC_NORMAL      16'hFFFC
`define ABU_VEC_MONITOR     16'hFEFC
`define ABU_RESET_BYTE      8'h00
`define ABU_RESP_OKAY       2'h0
`define ABU_RESP_SLVERR     2'h2
`endif

// ===== common/abu_pkg.sv
// Purpose: Types for the address breakpoint unit.
// Assumes: Nothing beyond the defines header.
// Notes: The break state machine uses abu_state_type.
package abu_pkg;
    typedef enum logic [1:0]
    {
        ABU_IDLE  = 2'b00,
        ABU_BREAK = 2'b01
    } abu_state_type;
    typedef logic [15:0] abu_addr_type;
endpackage : abu_pkg

// ===== hw/abu_sync3.sv
// Purpose: Three-stage synchroniser for a level from a pin.
// Assumes: The input is asynchronous to aclk.
// Notes: The output changes only when stages two and three agree.
`timescale 1ns/100ps
module abu_sync3 (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      dout
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            dout  <= 1'b0;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
            begin
                dout <= s3_ff;
            end
        end
    end
endmodule : abu_sync3

// ===== hw/abu_core.sv
// Purpose: Address breakpoint unit with AXI4-Lite registers and a CPU-side break handshake.
// Assumes: cpu_fetch_valid marks a program-counter address; cpu_last_cycle marks the
//          final cycle of an instruction; cpu_rti_done pulses when the return executes.
// Notes: The software interrupt opcode itself is forced by the integration unit.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "abu_defines.svh"
module abu_core (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [17:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [17:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire abu_pkg::abu_addr_type cpu_addr,
    input  wire logic                 cpu_fetch_valid,
    input  wire logic                 cpu_last_cycle,
    input  wire logic                 cpu_rti_done,
    input  wire logic                 monitor_mode,
    input  wire logic                 high_voltage_level,
    output logic                      breakpoint_request,
    output abu_pkg::abu_addr_type     break_vector,
    output logic                      timer_halt,
    output logic                      watchdog_disable,
    output logic                      break_clear_flag_enable,
    output logic                      irq
);
    import abu_pkg::*;

    abu_state_type state_ff;
    abu_state_type nxt_state;
    logic [7:0]    addr_high_ff;
    logic [7:0]    addr_low_ff;
    logic          break_enable_bit_ff;
    logic          break_active_flag_ff;
    logic          sim_break_flag_control_ff;
    logic [1:0]    irq_status_ff;
    logic [1:0]    irq_mask_ff;
    logic          hv_sync;
    logic          aw_hold_ff;
    logic          w_hold_ff;
    logic [15:0]   aw_idx_ff;
    logic [7:0]    w_byte_ff;
    logic          w_lane_ff;
    logic          addr_match;
    logic          sw_break;
    logic          sw_clear_active;
    logic          wr_fire;
    logic          wr_hit;
    logic          rd_hit;
    logic [15:0]   ar_idx;
    logic [7:0]    rd_byte;

    abu_sync3 u_hv_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (high_voltage_level),
        .dout    (hv_sync)
    );

    // The comparison uses all sixteen bits, only on program counter cycles.
    assign addr_match = break_enable_bit_ff && cpu_fetch_valid
                     && (cpu_addr == {addr_high_ff, addr_low_ff});

    // Write channel: address and data may arrive in either order.
    assign wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    assign wr_hit  = (aw_idx_ff == `ABU_IDX_ADDR_HIGH) || (aw_idx_ff == `ABU_IDX_ADDR_LOW)
                  || (aw_idx_ff == `ABU_IDX_STAT_CTRL) || (aw_idx_ff == `ABU_IDX_IRQ_STATUS)
                  || (aw_idx_ff == `ABU_IDX_IRQ_MASK)  || (aw_idx_ff == `ABU_IDX_SIM_CTRL);
    assign sw_break = wr_fire && w_lane_ff && (aw_idx_ff == `ABU_IDX_STAT_CTRL)
                   && w_byte_ff[`ABU_BIT_ACTIVE];
    assign sw_clear_active = wr_fire && w_lane_ff && (aw_idx_ff == `ABU_IDX_STAT_CTRL)
                          && !w_byte_ff[`ABU_BIT_ACTIVE];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_hold_ff    <= 1'b0;
            w_hold_ff     <= 1'b0;
            aw_idx_ff     <= 16'h0000;
            w_byte_ff     <= `ABU_RESET_BYTE;
            w_lane_ff     <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ABU_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_ff    <= 1'b1;
                aw_idx_ff     <= s_axi_awaddr[17:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_ff    <= 1'b1;
                w_byte_ff    <= s_axi_wdata[7:0];
                w_lane_ff    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `ABU_RESP_OKAY : `ABU_RESP_SLVERR;
                aw_hold_ff   <= 1'b0;
                w_hold_ff    <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Breakpoint address bytes, cleared by reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_high_ff <= `ABU_RESET_BYTE;
            addr_low_ff  <= `ABU_RESET_BYTE;
        end
        else if (wr_fire && w_lane_ff)
        begin
            if (aw_idx_ff == `ABU_IDX_ADDR_HIGH)
            begin
                addr_high_ff <= w_byte_ff;
            end
            if (aw_idx_ff == `ABU_IDX_ADDR_LOW)
            begin
                addr_low_ff <= w_byte_ff;
            end
        end
    end

    // Control bits and the integration unit flag control.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            break_enable_bit_ff       <= 1'b0;
            sim_break_flag_control_ff <= 1'b0;
            irq_mask_ff               <= 2'b00;
        end
        else if (wr_fire && w_lane_ff)
        begin
            if (aw_idx_ff == `ABU_IDX_STAT_CTRL)
            begin
                break_enable_bit_ff <= w_byte_ff[`ABU_BIT_ENABLE];
            end
            if (aw_idx_ff == `ABU_IDX_SIM_CTRL)
            begin
                sim_break_flag_control_ff <= w_byte_ff[0];
            end
            if (aw_idx_ff == `ABU_IDX_IRQ_MASK)
            begin
                irq_mask_ff <= w_byte_ff[1:0];
            end
        end
    end

    // A match or software write in the same cycle as a clear keeps the flag set.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            break_active_flag_ff <= 1'b0;
        end
        else if (addr_match || sw_break)
        begin
            break_active_flag_ff <= 1'b1;
        end
        else if (sw_clear_active)
        begin
            break_active_flag_ff <= 1'b0;
        end
    end

    // Break state: entered at once from the match cycle, left by the return.
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ABU_IDLE:
            begin
                if (addr_match || sw_break)
                begin
                    nxt_state = ABU_BREAK;
                end
            end
            ABU_BREAK:
            begin
                if (cpu_rti_done)
                begin
                    nxt_state = ABU_IDLE;
                end
            end
            default:
            begin
                nxt_state = ABU_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= ABU_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Outputs toward the integration unit, timer and watchdog.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            breakpoint_request      <= 1'b0;
            break_vector            <= `ABU_VEC_NORMAL;
            timer_halt              <= 1'b0;
            watchdog_disable        <= 1'b0;
            break_clear_flag_enable <= 1'b0;
            irq                     <= 1'b0;
        end
        else
        begin
            // The request stands until the break state ends so the opcode can be forced.
            breakpoint_request      <= (nxt_state == ABU_BREAK);
            break_vector            <= monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
            timer_halt              <= (nxt_state == ABU_BREAK);
            watchdog_disable        <= (nxt_state == ABU_BREAK) && hv_sync;
            break_clear_flag_enable <= sim_break_flag_control_ff;
            irq                     <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // Status bit 0: address match, bit 1: software break. Write one clears; set wins.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status_ff <= 2'b00;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if ((i == 0 && addr_match) || (i == 1 && sw_break))
                begin
                    irq_status_ff[i] <= 1'b1;
                end
                else if (wr_fire && w_lane_ff && aw_idx_ff == `ABU_IDX_IRQ_STATUS
                         && w_byte_ff[i])
                begin
                    irq_status_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    assign ar_idx = s_axi_araddr[17:2];
    assign rd_hit = (ar_idx == `ABU_IDX_ADDR_HIGH) || (ar_idx == `ABU_IDX_ADDR_LOW)
                 || (ar_idx == `ABU_IDX_STAT_CTRL) || (ar_idx == `ABU_IDX_IRQ_STATUS)
                 || (ar_idx == `ABU_IDX_IRQ_MASK)  || (ar_idx == `ABU_IDX_SIM_CTRL);

    always_comb
    begin
        rd_byte = 8'h00;
        case (ar_idx)
            `ABU_IDX_ADDR_HIGH:  rd_byte = addr_high_ff;
            `ABU_IDX_ADDR_LOW:   rd_byte = addr_low_ff;
            `ABU_IDX_STAT_CTRL:  rd_byte = {break_enable_bit_ff, break_active_flag_ff, 6'h00};
            `ABU_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_ff};
            `ABU_IDX_IRQ_MASK:   rd_byte = {6'h00, irq_mask_ff};
            `ABU_IDX_SIM_CTRL:   rd_byte = {7'h00, sim_break_flag_control_ff};
            default:             rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ABU_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_hit ? `ABU_RESP_OKAY : `ABU_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    a_match_request: assert property (@(posedge aclk) disable iff (!aresetn)
        addr_match |=> breakpoint_request)
        else $error("Address match did not raise the request.");
    a_fetch_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cpu_fetch_valid && state_ff == ABU_IDLE && !sw_break) |=> !breakpoint_request)
        else $error("Non-fetch cycle raised a request.");
    a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        addr_match |-> break_enable_bit_ff)
        else $error("Match counted while breaks disabled.");
    a_soft_break: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_break |=> (break_active_flag_ff && state_ff == ABU_BREAK))
        else $error("Software write of one did not break.");
    a_rti_exit: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == ABU_BREAK && cpu_rti_done) |=> ##1 !breakpoint_request)
        else $error("Return did not end the break state.");
    a_timer_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_halt == breakpoint_request)
        else $error("Timer not halted with the break.");
    a_watchdog_off: assert property (@(posedge aclk) disable iff (!aresetn)
        watchdog_disable |-> (breakpoint_request && $past(hv_sync)))
        else $error("Watchdog disabled without cause.");
    a_vector_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(monitor_mode) |-> break_vector == `ABU_VEC_MONITOR)
        else $error("Monitor vector not selected.");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (break_active_flag_ff && !sw_clear_active) |=> break_active_flag_ff)
        else $error("Active flag lost without a clear.");

    c_addr_break: cover property (@(posedge aclk) disable iff (!aresetn)
        addr_match ##[1:200] cpu_rti_done);
    c_last_match: cover property (@(posedge aclk) disable iff (!aresetn)
        addr_match && cpu_last_cycle);
    c_soft_break: cover property (@(posedge aclk) disable iff (!aresetn) sw_break);
    c_irq_raised: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : abu_core

// ===== tb/abu_cpu_model.sv
// Purpose: Behavioural CPU and integration unit facing the breakpoint unit.
// Assumes: Fetch and data cycles alternate; each fetch closes an instruction.
// Notes: During a break the bus shows a moving pattern, never a held address.
`timescale 1ns/100ps
module abu_cpu_model (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  run,
    input  wire abu_pkg::abu_addr_type start_pc,
    input  wire abu_pkg::abu_addr_type data_addr,
    input  wire logic [7:0]            rti_delay,
    input  wire logic                  breakpoint_request,
    output abu_pkg::abu_addr_type      cpu_addr,
    output logic                       cpu_fetch_valid,
    output logic                       cpu_last_cycle,
    output logic                       cpu_rti_done
);
    import abu_pkg::*;
    abu_addr_type pc_ff;
    logic         phase_ff;
    logic [7:0]   wait_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc_ff           <= 16'h0000;
            phase_ff        <= 1'h0;
            wait_ff         <= 8'h00;
            cpu_addr        <= 16'h0000;
            cpu_fetch_valid <= 1'h0;
            cpu_last_cycle  <= 1'h0;
            cpu_rti_done    <= 1'h0;
        end
        else if (breakpoint_request)
        begin
            // The forced opcode runs the handler; a slow handler delays the return.
            cpu_addr        <= ~cpu_addr;
            cpu_fetch_valid <= 1'h0;
            cpu_last_cycle  <= 1'h0;
            cpu_rti_done    <= (wait_ff == rti_delay);
            wait_ff         <= wait_ff + 8'h01;
        end
        else
        begin
            wait_ff         <= 8'h00;
            cpu_rti_done    <= 1'h0;
            phase_ff        <= run & ~phase_ff;
            cpu_fetch_valid <= run & ~phase_ff;
            cpu_last_cycle  <= run & ~phase_ff;
            cpu_addr        <= phase_ff ? data_addr : pc_ff;
            pc_ff           <= !run ? start_pc : (phase_ff ? pc_ff : pc_ff + 16'h0001);
        end
    end
endmodule : abu_cpu_model

// ===== tb/test_address_breakpoint_unit.sv
// Purpose: Self-checking bench for the address breakpoint unit.
// Assumes: One register access at a time; byte address is four times the index.
// Notes: Drivers queue expected bus and break results; watchers compare them.
`timescale 1ns/100ps
`include "abu_defines.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_address_breakpoint_unit;
    import abu_pkg::*;
    localparam logic [15:0] ST = `ABU_IDX_STAT_CTRL;
    localparam logic [15:0] IS = `ABU_IDX_IRQ_STATUS;
    localparam logic [1:0]  OK = `ABU_RESP_OKAY;
    logic         aclk = 1'h0, aresetn = 1'h0;
    logic [17:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]  s_axi_wdata = '0, s_axi_rdata, r;
    logic [3:0]   s_axi_wstrb = '0;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    abu_addr_type cpu_addr, break_vector, bp, start_pc = '0, data_addr = '0, prev_addr = '0;
    logic         cpu_fetch_valid, cpu_last_cycle, cpu_rti_done, breakpoint_request, timer_halt;
    logic         watchdog_disable, break_clear_flag_enable, irq, prev_fetch = 1'h0, req_d = 1'h0;
    logic         monitor_mode = 1'h0, high_voltage_level = 1'h0, run = 1'h0;
    logic [7:0]   rti_delay = 8'h50;
    logic [33:0]  exp_q[$];
    logic [32:0]  brk_q[$];
    logic [31:0]  seed = 32'h0000_8279;
    int           n_mismatch = 0, n_tests = 0, cycles = 0;

    always #2 aclk = ~aclk;

    abu_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu_addr, .cpu_fetch_valid, .cpu_last_cycle, .cpu_rti_done, .monitor_mode,
        .high_voltage_level, .breakpoint_request, .break_vector, .timer_halt, .watchdog_disable,
        .break_clear_flag_enable, .irq);
    abu_cpu_model partner (.aclk, .aresetn, .run, .start_pc, .data_addr, .rti_delay,
        .breakpoint_request, .cpu_addr, .cpu_fetch_valid, .cpu_last_cycle, .cpu_rti_done);

    function automatic logic [31:0] xs_next();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs_next

    task automatic end_sim();
        $display("TB: tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        exp_q.push_back({er, 32'h0000_0000});
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_awvalid <= 1'h1;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        exp_q.push_back({er, 24'h00_0000, d});
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask : axi_rd

    task automatic check_bus(input logic [33:0] got);
        logic [33:0] e;
        // An empty queue yields a value the bus can never carry, so a stray answer fails.
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
        `CHK(got, e)
    endtask : check_bus

    task automatic check_brk();
        logic [32:0] e;
        e = (brk_q.size() > 0) ? brk_q.pop_front() : 33'h1_FFFF_FFFF;
        if (e[32])
            `CHK({break_vector, timer_halt, prev_fetch, prev_addr}, {e[31:16], 2'h3, e[15:0]})
        else
            `CHK({break_vector, timer_halt}, {e[31:16], 1'h1})
    endtask : check_brk

    task automatic end_break();
        while (!cpu_rti_done)
            @(posedge aclk);
        repeat (3) @(posedge aclk);
        `CHK({breakpoint_request, timer_halt}, 2'h0)
    endtask : end_break

    always @(posedge aclk)
    begin
        cycles     <= cycles + 1;
        prev_fetch <= cpu_fetch_valid;
        prev_addr  <= cpu_addr;
        req_d      <= breakpoint_request;
        if (s_axi_bvalid && s_axi_bready)
            check_bus({s_axi_bresp, 32'h0000_0000});
        if (s_axi_rvalid && s_axi_rready)
            check_bus({s_axi_rresp, s_axi_rdata});
        if (breakpoint_request && !req_d)
            check_brk();
        if (cycles > 4000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(`ABU_IDX_ADDR_HIGH, 8'h00, OK);
        axi_rd(`ABU_IDX_ADDR_LOW, 8'h00, OK);
        axi_rd(ST, 8'h00, OK);
        repeat (3)
        begin
            r = xs_next();
            axi_wr(`ABU_IDX_ADDR_LOW, r[7:0], OK);
            axi_rd(`ABU_IDX_ADDR_LOW, r[7:0], OK);
        end
        r = xs_next();
        bp = r[15:0];
        axi_wr(`ABU_IDX_ADDR_HIGH, bp[15:8], OK);
        axi_wr(`ABU_IDX_ADDR_LOW, bp[7:0], OK);
        axi_rd(`ABU_IDX_ADDR_HIGH, bp[15:8], OK);
        axi_wr(ST, 8'hBF, OK);
        axi_rd(ST, 8'h80, OK);
        axi_wr(`ABU_IDX_IRQ_MASK, 8'h01, OK);
        // Data cycles hit the breakpoint before any fetch does; only the fetch may break.
        start_pc  <= bp - 16'h0006;
        data_addr <= bp;
        // The model loads its program counter only while stopped, so let one edge pass first.
        @(posedge aclk);
        run       <= 1'h1;
        brk_q.push_back({1'h1, `ABU_VEC_NORMAL, bp});
        while (!breakpoint_request)
            @(posedge aclk);
        axi_rd(ST, 8'hC0, OK);
        axi_rd(IS, 8'h01, OK);
        `CHK({irq, watchdog_disable}, 2'h2)
        axi_wr(ST, 8'h80, OK);
        axi_wr(IS, 8'h01, OK);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'h0)
        end_break();
        run <= 1'h0;
        axi_wr(ST, 8'h00, OK);
        run <= 1'h1;
        repeat (40) @(posedge aclk);
        run <= 1'h0;
        axi_rd(ST, 8'h00, OK);
        monitor_mode       <= 1'h1;
        high_voltage_level <= 1'h1;
        axi_wr(`ABU_IDX_IRQ_MASK, 8'h00, OK);
        brk_q.push_back({1'h0, `ABU_VEC_MONITOR, 16'h0000});
        axi_wr(ST, 8'h40, OK);
        while (!breakpoint_request)
            @(posedge aclk);
        repeat (3) @(posedge aclk);
        `CHK({irq, watchdog_disable}, 2'h1)
        axi_rd(IS, 8'h02, OK);
        axi_rd(ST, 8'h40, OK);
        axi_wr(`ABU_IDX_IRQ_MASK, 8'h02, OK);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'h1)
        axi_wr(IS, 8'h02, OK);
        axi_wr(ST, 8'h00, OK);
        `CHK(irq, 1'h0)
        end_break();
        `CHK(watchdog_disable, 1'h0)
        axi_wr(`ABU_IDX_SIM_CTRL, 8'h01, OK);
        repeat (2) @(posedge aclk);
        `CHK(break_clear_flag_enable, 1'h1)
        axi_rd(`ABU_IDX_SIM_CTRL, 8'h01, OK);
        axi_rd(16'hFE0F, 8'h00, `ABU_RESP_SLVERR);
        axi_wr(16'hFE0F, 8'hFF, `ABU_RESP_SLVERR);
        repeat (2) @(posedge aclk);
        end_sim();
    end
endmodule : test_address_breakpoint_unit
